/* File: logic/pid_consts.vh */
`ifndef PID_CONSTS_VH
`define PID_CONSTS_VH

// ------------------------------------------------------------
// Command block register addresses
// ------------------------------------------------------------
`define PID_A_DATA       3'h0
`define PID_A_ERR_FEAT   3'h1
`define PID_A_SECCNT     3'h2
`define PID_A_LBA_LO     3'h3
`define PID_A_LBA_MID    3'h4
`define PID_A_LBA_HI     3'h5
`define PID_A_DEVSEL     3'h6
`define PID_A_STAT_CMD   3'h7

// ------------------------------------------------------------
// Status byte bit positions
// ------------------------------------------------------------
`define PID_ST_BSY       7
`define PID_ST_DRDY      6
`define PID_ST_DF        5
`define PID_ST_DRQ       3
`define PID_ST_ERR       0

// ------------------------------------------------------------
// Other bit positions and codes
// ------------------------------------------------------------
`define PID_DEV_BIT      4
`define PID_NIEN_BIT     1
`define PID_ABRT_BIT     2
`define PID_OP_IDENT     8'hA1
`define PID_LAST_WORD    8'hFF

// ------------------------------------------------------------
// Parameter block word indices
// ------------------------------------------------------------
`define PID_W_CONFIG     8'h00
`define PID_W_SER_LO     8'h0A
`define PID_W_SER_HI     8'h13
`define PID_W_FW_LO      8'h17
`define PID_W_FW_HI      8'h1A
`define PID_W_MOD_LO     8'h1B
`define PID_W_MOD_HI     8'h2E
`define PID_W_CAP49      8'h31
`define PID_W_CAP50      8'h32
`define PID_W_VALID53    8'h35

// ------------------------------------------------------------
// Word 0 field values
// ------------------------------------------------------------
`define PID_W0_PACKET    2'h2
`define PID_DRQ_3MS      2'h0
`define PID_DRQ_50US     2'h2
`define PID_PKT_12       2'h0
`define PID_PKT_16       2'h1

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define PID_CLK_NS       10
`define PID_LIMIT_50US_NS 50000
`define PID_LIMIT_3MS_NS  3000000
`define PID_PREP_NS      2000

`endif

/* File: logic/pid_word_rom.v */
`timescale 1ns/1ps
`default_nettype none
`include "pid_consts.vh"

module pid_word_rom #(
  parameter [4:0]   PKT_SET   = 5'h05,
  parameter         REMOVABLE = 1'b1,
  parameter [1:0]   DRQ_SPEED = `PID_DRQ_50US,
  parameter [1:0]   PKT_LEN   = `PID_PKT_12,
  parameter [159:0] SERIAL    = "00000000000000000001",
  parameter [63:0]  FIRMWARE  = "REV 0001",
  parameter [319:0] MODEL     = "GENERIC PACKET DEVICE                   ",
  parameter [6:0]   CAP_HI    = 7'h08,
  parameter [7:0]   CAP_VEND  = 8'h00,
  parameter         W88_OK    = 1'b0,
  parameter         W64_OK    = 1'b1
) (
  input  wire [7:0]  word_idx_in,
  output reg  [15:0] word_out
);

  // ----------------------------------------------------------
  // Word selection
  // ----------------------------------------------------------
  wire [7:0] ser_k = word_idx_in - `PID_W_SER_LO;
  wire [7:0] fw_k  = word_idx_in - `PID_W_FW_LO;
  wire [7:0] mod_k = word_idx_in - `PID_W_MOD_LO;

  always @*
  begin
    word_out = 16'h0000;
    if (word_idx_in == `PID_W_CONFIG)
      word_out = {`PID_W0_PACKET, 1'b0, PKT_SET,
                  REMOVABLE, DRQ_SPEED, 2'b00,
                  1'b0, PKT_LEN};
    else if (word_idx_in >= `PID_W_SER_LO &&
             word_idx_in <= `PID_W_SER_HI)
      word_out = SERIAL[159 - {ser_k[3:0], 4'h0} -: 16];
    else if (word_idx_in >= `PID_W_FW_LO &&
             word_idx_in <= `PID_W_FW_HI)
      word_out = FIRMWARE[63 - {fw_k[1:0], 4'h0} -: 16];
    else if (word_idx_in >= `PID_W_MOD_LO &&
             word_idx_in <= `PID_W_MOD_HI)
      word_out = MODEL[319 - {mod_k[4:0], 4'h0} -: 16];
    else if (word_idx_in == `PID_W_CAP49)
      word_out = {CAP_HI[6:4], 1'b0, CAP_HI[2:1],
                  1'b1, CAP_HI[0], CAP_VEND};
    else if (word_idx_in == `PID_W_CAP50)
      word_out = {1'b0, 1'b1, 13'h0000, 1'b1};
    else if (word_idx_in == `PID_W_VALID53)
      word_out = {13'h0000, W88_OK, W64_OK, 1'b0};
  end

endmodule
`default_nettype wire

/* File: logic/pid_responder.v */
// What this block does
// - Good completion leaves BSY, DF, DRQ, ERR clear and DRDY set.
// - Device register keeps reporting which device on the cable is selected.
// - Without the command, abort it; with it, never report an error.
// - The command runs whether DRDY is set or clear.
// - Command sets BSY, prepares 256 words, sets DRQ, clears BSY, interrupts.
// - Reserved bits and words of the block read as zero.
// - Bit n of a bit-significant word goes out on data line n.
// - A 16-bit value goes out MSB on line 15, LSB on line 0.
// - A 32-bit value goes out low half first, then high half.
// - Word 0 bits 15-14 hold 10 for a packet device.
// - Word 0 bits 12-8 give packet set; bit 7 flags removable media.
// - Word 0 bits 6-5 declare DRQ speed; the device meets that limit.
// - Word 0 bit 2 flags incomplete data; bits 1-0 give packet length.
// - Serial, firmware and model strings sit in words 10-19, 23-26, 27-46.
// - Word 49 carries capability flags with bit 9 fixed at one.
// - Word 50 drives bit 15 zero, bit 14 one, bit 0 one.
// - Word 53 bits 2 and 1 mark words 88 and 64-70 valid.
// - Packet-command devices carry this command; others must not.
// - Data moves under the PIO data-in protocol.
`timescale 1ns/1ps
`default_nettype none
`include "pid_consts.vh"

module pid_responder #(
  parameter         IMPLEMENTED = 1'b1,
  parameter [4:0]   PKT_SET     = 5'h05,
  parameter         REMOVABLE   = 1'b1,
  parameter [1:0]   DRQ_SPEED   = `PID_DRQ_50US,
  parameter [1:0]   PKT_LEN     = `PID_PKT_12,
  parameter [159:0] SERIAL      = "00000000000000000001",
  parameter [63:0]  FIRMWARE    = "REV 0001",
  parameter [319:0] MODEL       = "GENERIC PACKET DEVICE                   ",
  parameter [6:0]   CAP_HI      = 7'h08,
  parameter [7:0]   CAP_VEND    = 8'h00,
  parameter         W88_OK      = 1'b0,
  parameter         W64_OK      = 1'b1
) (
  input  wire        core_clk_in,
  input  wire        nrst_in,
  input  wire [2:0]  reg_addr_in,
  input  wire        reg_rd_in,
  input  wire        reg_wr_in,
  input  wire [15:0] reg_wdata_in,
  input  wire        ctl_wr_in,
  input  wire [7:0]  ctl_wdata_in,
  input  wire        dev_pos_in,
  output wire [15:0] reg_rdata_out,
  output wire        intrq_out,
  output wire        busy_out,
  output wire        drq_out
);

  // ----------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------
  localparam integer LIMIT_NS = (DRQ_SPEED == `PID_DRQ_50US) ?
                                `PID_LIMIT_50US_NS : `PID_LIMIT_3MS_NS;
  localparam integer PREP_NS  = (`PID_PREP_NS < LIMIT_NS) ?
                                `PID_PREP_NS : LIMIT_NS;
  localparam integer PREP_CYC_I = (PREP_NS / `PID_CLK_NS) < 1 ? 1 :
                                  (PREP_NS / `PID_CLK_NS);
  localparam [19:0]  PREP_CYC = PREP_CYC_I[19:0];

  // ----------------------------------------------------------
  // States
  // ----------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_PREP = 3'b010;
  localparam [2:0] ST_XFER = 3'b100;

  // ----------------------------------------------------------
  // Status byte assembly
  // ----------------------------------------------------------
  function [7:0] stat_byte;
    input bsy;
    input drdy;
    input df;
    input drq;
    input err;
    begin
      stat_byte = 8'h00;
      stat_byte[`PID_ST_BSY]  = bsy;
      stat_byte[`PID_ST_DRDY] = drdy;
      stat_byte[`PID_ST_DF]   = df;
      stat_byte[`PID_ST_DRQ]  = drq;
      stat_byte[`PID_ST_ERR]  = err;
    end
  endfunction

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  reg [2:0]  state_r;
  reg [2:0]  state_nxt;
  reg [19:0] prep_cnt_r;
  reg [19:0] prep_cnt_nxt;
  reg [7:0]  word_idx_r;
  reg [7:0]  word_idx_nxt;
  reg        bsy_r;
  reg        bsy_nxt;
  reg        drdy_r;
  reg        drdy_nxt;
  reg        drq_r;
  reg        drq_nxt;
  reg        err_r;
  reg        err_nxt;
  reg        abrt_r;
  reg        abrt_nxt;
  reg        intrq_r;
  reg        intrq_nxt;
  reg        nien_r;
  reg [7:0]  devsel_r;
  reg        dev_pos_r;
  reg        strap_done_r;
  reg [15:0] rdata_r;
  reg [15:0] rdata_nxt;
  reg [7:0]  tf_r [1:5];

  wire [15:0] rom_word;
  wire        selected = (devsel_r[`PID_DEV_BIT] == dev_pos_r);
  wire        cmd_wr   = reg_wr_in && (reg_addr_in == `PID_A_STAT_CMD)
                         && selected;
  wire        data_rd  = reg_rd_in && (reg_addr_in == `PID_A_DATA);
  wire        stat_rd  = reg_rd_in && (reg_addr_in == `PID_A_STAT_CMD);
  wire        is_ident = (reg_wdata_in[7:0] == `PID_OP_IDENT);

  assign reg_rdata_out = rdata_r;
  assign intrq_out     = intrq_r;
  assign busy_out      = bsy_r;
  assign drq_out       = drq_r;

  // ----------------------------------------------------------
  // Parameter block
  // ----------------------------------------------------------
  pid_word_rom #(
    .PKT_SET   (PKT_SET),
    .REMOVABLE (REMOVABLE),
    .DRQ_SPEED (DRQ_SPEED),
    .PKT_LEN   (PKT_LEN),
    .SERIAL    (SERIAL),
    .FIRMWARE  (FIRMWARE),
    .MODEL     (MODEL),
    .CAP_HI    (CAP_HI),
    .CAP_VEND  (CAP_VEND),
    .W88_OK    (W88_OK),
    .W64_OK    (W64_OK)
  ) u_rom (
    .word_idx_in (word_idx_r),
    .word_out    (rom_word)
  );

  // ----------------------------------------------------------
  // Position strap, caught after reset release
  // ----------------------------------------------------------
  always @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      dev_pos_r    <= 1'b0;
      strap_done_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      dev_pos_r    <= dev_pos_in;
      strap_done_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------
  // Task file, device select and control writes
  // ----------------------------------------------------------
  genvar g;
  generate
    for (g = 1; g <= 5; g = g + 1)
    begin : g_tf
      always @(posedge core_clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
          tf_r[g] <= 8'h00;
        else if (reg_wr_in && reg_addr_in == g)
          tf_r[g] <= reg_wdata_in[7:0];
      end
    end
  endgenerate

  always @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      devsel_r <= 8'h00;
      nien_r   <= 1'b0;
    end
    else
    begin
      if (reg_wr_in && reg_addr_in == `PID_A_DEVSEL)
        devsel_r <= reg_wdata_in[7:0];
      if (ctl_wr_in)
        nien_r <= ctl_wdata_in[`PID_NIEN_BIT];
    end
  end

  // ----------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------
  always @*
  begin
    state_nxt    = state_r;
    prep_cnt_nxt = prep_cnt_r;
    word_idx_nxt = word_idx_r;
    bsy_nxt      = bsy_r;
    drdy_nxt     = drdy_r;
    drq_nxt      = drq_r;
    err_nxt      = err_r;
    abrt_nxt     = abrt_r;
    intrq_nxt    = intrq_r;
    if (stat_rd && selected)
      intrq_nxt = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        if (cmd_wr)
        begin
          intrq_nxt = 1'b0;
          if (is_ident && IMPLEMENTED)
          begin
            bsy_nxt      = 1'b1;
            err_nxt      = 1'b0;
            abrt_nxt     = 1'b0;
            prep_cnt_nxt = PREP_CYC;
            word_idx_nxt = 8'h00;
            state_nxt    = ST_PREP;
          end
          else
          begin
            err_nxt   = 1'b1;
            abrt_nxt  = 1'b1;
            drdy_nxt  = 1'b1;
            intrq_nxt = !nien_r;
          end
        end
      end
      ST_PREP:
      begin
        if (prep_cnt_r == 20'h0_0001)
        begin
          bsy_nxt   = 1'b0;
          drq_nxt   = 1'b1;
          intrq_nxt = !nien_r;
          state_nxt = ST_XFER;
        end
        else
          prep_cnt_nxt = prep_cnt_r - 20'h0_0001;
      end
      ST_XFER:
      begin
        if (data_rd)
        begin
          word_idx_nxt = word_idx_r + 8'h01;
          if (word_idx_r == `PID_LAST_WORD)
          begin
            drq_nxt   = 1'b0;
            drdy_nxt  = 1'b1;
            err_nxt   = 1'b0;
            state_nxt = ST_IDLE;
          end
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
        bsy_nxt   = 1'b0;
        drq_nxt   = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------
  // Read data
  // ----------------------------------------------------------
  always @*
  begin
    rdata_nxt = rdata_r;
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        `PID_A_DATA:
          rdata_nxt = (state_r == ST_XFER) ?
                      rom_word : 16'h0000;
        `PID_A_ERR_FEAT:
          rdata_nxt = {13'h0000, abrt_r, 2'b00};
        `PID_A_SECCNT, `PID_A_LBA_LO, `PID_A_LBA_MID,
        `PID_A_LBA_HI:
          rdata_nxt = {8'h00, tf_r[reg_addr_in]};
        `PID_A_DEVSEL:
          rdata_nxt = {8'h00, devsel_r};
        `PID_A_STAT_CMD:
          rdata_nxt = {8'h00, stat_byte(bsy_r, drdy_r,
                                        1'b0, drq_r, err_r)};
        default:
          rdata_nxt = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  always @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_r    <= ST_IDLE;
      prep_cnt_r <= 20'h0_0000;
      word_idx_r <= 8'h00;
      bsy_r      <= 1'b0;
      drdy_r     <= 1'b1;
      drq_r      <= 1'b0;
      err_r      <= 1'b0;
      abrt_r     <= 1'b0;
      intrq_r    <= 1'b0;
      rdata_r    <= 16'h0000;
    end
    else
    begin
      state_r    <= state_nxt;
      prep_cnt_r <= prep_cnt_nxt;
      word_idx_r <= word_idx_nxt;
      bsy_r      <= bsy_nxt;
      drdy_r     <= drdy_nxt;
      drq_r      <= drq_nxt;
      err_r      <= err_nxt;
      abrt_r     <= abrt_nxt;
      intrq_r    <= intrq_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

endmodule
`default_nettype wire

/* File: dv/pid_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module pid_asserts (
  input wire logic        core_clk_in,
  input wire logic        nrst_in,
  input wire logic [2:0]  reg_addr_in,
  input wire logic        reg_rd_in,
  input wire logic        reg_wr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic        intrq_out,
  input wire logic        busy_out,
  input wire logic        drq_out
);
  // ------------------------------------------------------------
  // Request history
  // ------------------------------------------------------------
  logic id_wr_r;
  logic cmd_wr_r;
  logic dat_rd_r;
  always @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      id_wr_r  <= 1'b0;
      cmd_wr_r <= 1'b0;
      dat_rd_r <= 1'b0;
    end
    else
    begin
      cmd_wr_r <= reg_wr_in && reg_addr_in == 3'h7;
      id_wr_r  <= reg_wr_in && reg_addr_in == 3'h7 &&
                  reg_wdata_in[7:0] == 8'ha1;
      dat_rd_r <= reg_rd_in && reg_addr_in == 3'h0;
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  a_busy_drq_excl: assert property (!(busy_out && drq_out))
    else $error("busy and drq both high");
  a_busy_from_ident: assert property ($rose(busy_out) |-> id_wr_r)
    else $error("busy without identify opcode");
  a_busy_bounded: assert property ($rose(busy_out) |-> ##[1:300] !busy_out)
    else $error("busy too long");
  a_busy_to_drq: assert property ($fell(busy_out) |-> drq_out)
    else $error("busy fell without drq");
  a_intrq_cause: assert property
    ($rose(intrq_out) |-> $rose(drq_out) || cmd_wr_r)
    else $error("intrq without cause");
  a_drq_holds: assert property (drq_out && !reg_rd_in |=> drq_out)
    else $error("drq dropped without read");
  a_drq_end_read: assert property ($fell(drq_out) |-> dat_rd_r)
    else $error("drq fell without data read");
  a_status_done: assert property
    (reg_rd_in && reg_addr_in == 3'h7 && !busy_out && !drq_out |=>
     reg_rdata_out[7:5] == 3'b010 && !reg_rdata_out[3])
    else $error("bad idle status");
  a_intrq_clear: assert property
    (reg_rd_in && reg_addr_in == 3'h7 && !busy_out && !drq_out |=> !intrq_out)
    else $error("status read left intrq");
  c_ident: cover property ($fell(drq_out));
  c_abort: cover property (cmd_wr_r && !busy_out && intrq_out);
  c_intrq: cover property ($rose(drq_out) && !intrq_out);
endmodule
`default_nettype wire

/* File: dv/pid_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pid_host_model (
  input  wire logic        core_clk_in,
  input  wire logic [15:0] reg_rdata_in,
  output var  logic [2:0]  reg_addr_out,
  output var  logic        reg_rd_out,
  output var  logic        reg_wr_out,
  output var  logic [15:0] reg_wdata_out,
  output var  logic        ctl_wr_out,
  output var  logic [7:0]  ctl_wdata_out
);
  initial
  begin
    reg_addr_out  = 3'h0;
    reg_rd_out    = 1'b0;
    reg_wr_out    = 1'b0;
    reg_wdata_out = 16'h5a5a;
    ctl_wr_out    = 1'b0;
    ctl_wdata_out = 8'h00;
  end
  // Register write, one strobe cycle
  task wr(input logic [2:0] a, input logic [15:0] v);
    begin
      @(posedge core_clk_in);
      #1;
      reg_addr_out  = a;
      reg_wdata_out = v;
      reg_wr_out    = 1'b1;
      @(posedge core_clk_in);
      #1;
      reg_wr_out    = 1'b0;
      reg_wdata_out = ~v;
    end
  endtask
  // One word per data read
  task rd(input logic [2:0] a, output logic [15:0] v);
    begin
      @(posedge core_clk_in);
      #1;
      reg_addr_out = a;
      reg_rd_out   = 1'b1;
      @(posedge core_clk_in);
      #1;
      reg_rd_out   = 1'b0;
      v            = reg_rdata_in;
    end
  endtask
  // Device control write
  task ctl(input logic [7:0] v);
    begin
      @(posedge core_clk_in);
      #1;
      ctl_wdata_out = v;
      ctl_wr_out    = 1'b1;
      @(posedge core_clk_in);
      #1;
      ctl_wr_out    = 1'b0;
      ctl_wdata_out = ~v;
    end
  endtask
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  error_cnt++; $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  localparam [159:0] SER = "00000000000000000001";
  localparam [63:0]  FWR = "REV 0001";
  localparam [319:0] MDL = "GENERIC PACKET DEVICE                   ";
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [2:0]  addr;
  logic        rd;
  logic        wr;
  logic [15:0] wdata;
  logic        cwr;
  logic [7:0]  cdata;
  logic [15:0] rdata;
  logic        intrq;
  logic        busy;
  logic        drq;
  logic [15:0] d;
  logic [31:0] seed = 32'h0000_87c3;
  logic [7:0]  op;
  logic        pos = 1'b0;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          n;
  always #5 clk = ~clk;
  pid_responder pid_responder_inst (.core_clk_in(clk), .nrst_in(nrst),
    .reg_addr_in(addr), .reg_rd_in(rd), .reg_wr_in(wr),
    .reg_wdata_in(wdata), .ctl_wr_in(cwr), .ctl_wdata_in(cdata),
    .dev_pos_in(pos), .reg_rdata_out(rdata), .intrq_out(intrq),
    .busy_out(busy), .drq_out(drq));
  pid_host_model pid_host_model_inst (.core_clk_in(clk),
    .reg_rdata_in(rdata), .reg_addr_out(addr), .reg_rd_out(rd),
    .reg_wr_out(wr), .reg_wdata_out(wdata), .ctl_wr_out(cwr),
    .ctl_wdata_out(cdata));
  function logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // ------------------------------------------------------------
  // Expected parameter block
  // ------------------------------------------------------------
  function logic [15:0] exp_word(input int i);
    begin
      exp_word = 16'h0000;
      if (i == 0) exp_word = 16'h85c0;
      if (i >= 10 && i <= 19) exp_word = SER[159 - 16 * (i - 10) -: 16];
      if (i >= 23 && i <= 26) exp_word = FWR[63 - 16 * (i - 23) -: 16];
      if (i >= 27 && i <= 46) exp_word = MDL[319 - 16 * (i - 27) -: 16];
      if (i == 49) exp_word = 16'h0200;
      if (i == 50) exp_word = 16'h4001;
      if (i == 53) exp_word = 16'h0002;
    end
  endfunction
  task finish_test;
    begin
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      finish_test;
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (2) @(posedge clk);
    pid_host_model_inst.rd(3'h7, d);
    `CHK("reset status", 8'h40, d[7:0])
    for (int k = 0; k < 2; k++)
    begin
      seed = lfsr(seed);
      pid_host_model_inst.wr(3'h6, {8'h00, seed[7:5], 1'b0, seed[3:0]});
      pid_host_model_inst.ctl({6'h00, k[0], 1'b0});
      pid_host_model_inst.wr(3'h7, 16'h00a1);
      `CHK("busy", 1'b1, busy)
      n = 0;
      while (drq !== 1'b1 && n < 5000)
      begin
        @(posedge clk);
        #1 n++;
      end
      `CHK("drq", 1'b1, drq)
      `CHK("busy end", 1'b0, busy)
      `CHK("intrq", ~k[0], intrq)
      for (int w = 0; w < 256; w++)
      begin
        pid_host_model_inst.rd(3'h0, d);
        `CHK("word", exp_word(w), d)
      end
      `CHK("drq done", 1'b0, drq)
      pid_host_model_inst.rd(3'h0, d);
      `CHK("idle data", 16'h0000, d)
      pid_host_model_inst.rd(3'h7, d);
      `CHK("status", 8'h40, d[7:0])
      `CHK("intrq clr", 1'b0, intrq)
      pid_host_model_inst.rd(3'h1, d);
      `CHK("no error", 1'b0, d[2])
      pid_host_model_inst.rd(3'h6, d);
      `CHK("dev bit", 1'b0, d[4])
    end
    seed = lfsr(seed);
    op = (seed[7:0] == 8'ha1) ? 8'hb0 : seed[7:0];
    pid_host_model_inst.ctl(8'h00);
    pid_host_model_inst.wr(3'h7, {8'h00, op});
    `CHK("abort busy", 1'b0, busy)
    `CHK("abort intrq", 1'b1, intrq)
    pid_host_model_inst.rd(3'h7, d);
    `CHK("abort status", 8'h41, d[7:0])
    pid_host_model_inst.rd(3'h1, d);
    `CHK("abort code", 1'b1, d[2])
    pid_host_model_inst.wr(3'h6, 16'h0010);
    pid_host_model_inst.wr(3'h7, 16'h00a1);
    repeat (3) @(posedge clk);
    `CHK("other dev busy", 1'b0, busy)
    `CHK("other dev drq", 1'b0, drq)
    pid_host_model_inst.wr(3'h6, 16'h0000);
    pos = 1'b1;
    #1 nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    `CHK("reset busy", 1'b0, busy)
    `CHK("reset intrq", 1'b0, intrq)
    repeat (2) @(posedge clk);
    pid_host_model_inst.wr(3'h6, 16'h0010);
    pid_host_model_inst.wr(3'h7, 16'h00a1);
    `CHK("pos1 busy", 1'b1, busy)
    pid_host_model_inst.rd(3'h6, d);
    `CHK("pos1 dev bit", 1'b1, d[4])
    finish_test;
  end
endmodule
bind pid_responder pid_asserts pid_asserts_inst (
  .core_clk_in(core_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
  .reg_rd_in(reg_rd_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .intrq_out(intrq_out),
  .busy_out(busy_out), .drq_out(drq_out));
`default_nettype wire
